// ---- hw/mpa_pkg.sv ----
// constants and carrier types for memory policy and aperture control
// Operation
// [RULE1] policy 0: page miss precharges addressed bank
// [RULE2] policy 1: page miss precharges all banks
// [RULE3] row change with open pages precharges all
// [RULE4] precharge all leads every refresh
// [RULE5] frequency bit: 0 is 100 MHz, 1 is 133 MHz
// [RULE6] frequency bit resets from sampled strap pin
// [RULE7] lock bit accepts only first write after reset
// [RULE8] lock set makes graphics select read only
// [RULE9] aperture enable resets 0, blocks all ports
// [RULE10] select 0: devices 0,1 visible, device 2 ones
// [RULE11] select 1: device 1 ones, AGP registers zero
// [RULE12] internal graphics needs smm field and select
// [RULE13] software programs select before other configuration
// [RULE14] software enables aperture after table setup
// [RULE15] reserved bits read zero, writes ignored
package mpa_pkg;

  // ****************************************
  // configuration map
  // ****************************************
  localparam logic [7:0] MPA_OFF_MEMCTL = 8'h50;
  localparam logic [7:0] MPA_OFF_APERTURE = 8'h51;
  localparam logic [1:0] MPA_DEV_HOST = 2'h0;
  localparam logic [1:0] MPA_DEV_AGP = 2'h1;
  localparam logic [1:0] MPA_DEV_GRAPHICS = 2'h2;

  // ****************************************
  // field positions and values
  // ****************************************
  localparam int MPA_BIT_POLICY = 3;
  localparam int MPA_BIT_FREQ = 2;
  localparam int MPA_BIT_LOCK = 2;
  localparam int MPA_BIT_APEN = 1;
  localparam int MPA_BIT_SEL = 0;
  localparam logic [7:0] MPA_MEMCTL_EXT_MASK = 8'hF0;
  localparam logic [7:0] MPA_APERTURE_RESET = 8'h00;
  localparam logic [7:0] MPA_ALL_ONES = 8'hFF;
  localparam logic [7:0] MPA_ALL_ZEROS = 8'h00;
  localparam logic [1:0] MPA_SMM_OFF = 2'h0;
  localparam logic MPA_FREQ_100 = 1'b0;
  localparam logic MPA_FREQ_133 = 1'b1;
  localparam logic MPA_SEL_AGP = 1'b0;
  localparam logic MPA_SEL_GRAPHICS = 1'b1;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] dev;
    logic [7:0] off;
    logic [7:0] wdata;
  } mpa_cfg_req_t;

  typedef struct packed {
    logic page_miss;
    logic row_switch;
    logic pages_open;
    logic refresh_req;
  } mpa_dram_evt_t;

  typedef struct packed {
    logic cpu;
    logic pci;
    logic agp;
  } mpa_port_t;

  typedef struct packed {
    logic strap_s1;
    logic strap_s2;
    logic page_close_policy;
    logic sysmem_freq_select;
    logic graphics_select_lock;
    logic lock_written;
    logic aperture_enable;
    logic graphics_device_select;
    logic [7:0] rdata;
    logic rd_valid;
    logic precharge_bank;
    logic precharge_all;
    logic refresh_go;
    logic refresh_pend;
  } mpa_state_t;

endpackage

// ---- hw/mpa_ctrl.sv ----
// memory page policy, memory frequency and aperture control registers
`timescale 1ns/1ps
module mpa_ctrl
  import mpa_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic sysmem_freq_strap_pin,
  input wire mpa_cfg_req_t cfg_req,
  input wire logic [7:0] cfg_ext_rdata,
  input wire logic cfg_ext_agp_reg,
  input wire logic [1:0] smm_ram_control,
  input wire mpa_dram_evt_t dram_evt,
  input wire mpa_port_t aperture_req,
  output mpa_port_t aperture_grant,
  output logic [7:0] cfg_rdata,
  output logic cfg_rd_valid,
  output logic cfg_fwd_rd,
  output logic cfg_fwd_wr,
  output logic page_close_policy,
  output logic sysmem_freq_select,
  output logic graphics_device_select,
  output logic agp_device_enable,
  output logic internal_graphics_claim,
  output logic precharge_bank,
  output logic precharge_all,
  output logic refresh_go
);

  // ****************************************
  // state
  // ****************************************
  mpa_state_t st_ff;
  mpa_state_t nxt_st;

  function automatic logic hit(input mpa_cfg_req_t r, input logic [1:0] d, input logic [7:0] o);
    hit = (r.dev == d) && (r.off == o);
  endfunction

  logic wr_memctl;
  logic wr_aperture;
  logic rd_memctl;
  logic rd_aperture;
  logic dev_visible;
  logic agp_hidden;
  logic graphics_claim;

  // ****************************************
  // configuration decode
  // ****************************************
  always_comb begin
    wr_memctl = cfg_req.wr && hit(cfg_req, MPA_DEV_HOST, MPA_OFF_MEMCTL);
    wr_aperture = cfg_req.wr && hit(cfg_req, MPA_DEV_HOST, MPA_OFF_APERTURE);
    rd_memctl = cfg_req.rd && hit(cfg_req, MPA_DEV_HOST, MPA_OFF_MEMCTL);
    rd_aperture = cfg_req.rd && hit(cfg_req, MPA_DEV_HOST, MPA_OFF_APERTURE);
    // internal graphics answers only when smm space is set up as well
    graphics_claim = (st_ff.graphics_device_select == MPA_SEL_GRAPHICS)
      && (smm_ram_control != MPA_SMM_OFF); // [RULE12]
    agp_hidden = (st_ff.graphics_device_select == MPA_SEL_GRAPHICS)
      && (cfg_req.dev == MPA_DEV_HOST) && cfg_ext_agp_reg; // [RULE11]
    unique case (cfg_req.dev)
      MPA_DEV_HOST: dev_visible = !agp_hidden;
      MPA_DEV_AGP: dev_visible = (st_ff.graphics_device_select == MPA_SEL_AGP); // [RULE10]
      MPA_DEV_GRAPHICS: dev_visible = graphics_claim; // [RULE11] [RULE12]
      default: dev_visible = 1'b0;
    endcase
  end

  // offset 51h is held here; everything else visible goes outward
  assign cfg_fwd_rd = cfg_req.rd && dev_visible && !rd_aperture;
  assign cfg_fwd_wr = cfg_req.wr && dev_visible && !wr_aperture;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.strap_s1 = sysmem_freq_strap_pin;
    nxt_st.strap_s2 = st_ff.strap_s1;
    nxt_st.rd_valid = cfg_req.rd;
    nxt_st.precharge_bank = 1'b0;
    nxt_st.precharge_all = 1'b0;
    nxt_st.refresh_go = 1'b0;
    nxt_st.refresh_pend = 1'b0;
    if (rst) begin
      nxt_st.page_close_policy = 1'b0;
      // strap has passed the synchroniser before it is caught
      nxt_st.sysmem_freq_select = st_ff.strap_s2; // [RULE6]
      nxt_st.graphics_select_lock = MPA_APERTURE_RESET[MPA_BIT_LOCK];
      nxt_st.lock_written = 1'b0;
      nxt_st.aperture_enable = MPA_APERTURE_RESET[MPA_BIT_APEN]; // [RULE9]
      nxt_st.graphics_device_select = MPA_APERTURE_RESET[MPA_BIT_SEL];
      nxt_st.rdata = MPA_ALL_ZEROS;
      nxt_st.rd_valid = 1'b0;
    end else begin
      if (wr_memctl) begin
        nxt_st.page_close_policy = cfg_req.wdata[MPA_BIT_POLICY];
        nxt_st.sysmem_freq_select = cfg_req.wdata[MPA_BIT_FREQ]; // [RULE5]
      end
      if (wr_aperture) begin
        nxt_st.aperture_enable = cfg_req.wdata[MPA_BIT_APEN];
        if (!st_ff.graphics_select_lock) begin
          nxt_st.graphics_device_select = cfg_req.wdata[MPA_BIT_SEL]; // [RULE8]
        end
        if (!st_ff.lock_written) begin
          nxt_st.graphics_select_lock = cfg_req.wdata[MPA_BIT_LOCK]; // [RULE7]
          nxt_st.lock_written = 1'b1; // [RULE7]
        end
      end
      // read answer, one cycle after the request
      if (rd_aperture) begin
        nxt_st.rdata = MPA_ALL_ZEROS; // [RULE15]
        nxt_st.rdata[MPA_BIT_LOCK] = st_ff.graphics_select_lock;
        nxt_st.rdata[MPA_BIT_APEN] = st_ff.aperture_enable;
        nxt_st.rdata[MPA_BIT_SEL] = st_ff.graphics_device_select;
      end else if (rd_memctl) begin
        // low reserved bits forced to zero, upper fields come from outside
        nxt_st.rdata = cfg_ext_rdata & MPA_MEMCTL_EXT_MASK; // [RULE15]
        nxt_st.rdata[MPA_BIT_POLICY] = st_ff.page_close_policy;
        nxt_st.rdata[MPA_BIT_FREQ] = st_ff.sysmem_freq_select;
      end else if (agp_hidden) begin
        nxt_st.rdata = MPA_ALL_ZEROS; // [RULE11]
      end else if (!dev_visible) begin
        nxt_st.rdata = MPA_ALL_ONES; // [RULE10] [RULE11]
      end else begin
        nxt_st.rdata = cfg_ext_rdata;
      end
      // precharge commands; precharge all covers a bank precharge
      if ((dram_evt.row_switch && dram_evt.pages_open)
          || dram_evt.refresh_req
          || (dram_evt.page_miss && st_ff.page_close_policy)) begin
        nxt_st.precharge_all = 1'b1; // [RULE2] [RULE3] [RULE4]
      end else if (dram_evt.page_miss) begin
        nxt_st.precharge_bank = 1'b1; // [RULE1]
      end
      // refresh waits one cycle behind its precharge all, which a request always raises
      nxt_st.refresh_pend = dram_evt.refresh_req;
      nxt_st.refresh_go = st_ff.refresh_pend; // [RULE4]
    end
  end

  always_ff @(posedge clock) begin
    st_ff <= nxt_st;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign cfg_rdata = st_ff.rdata;
  assign cfg_rd_valid = st_ff.rd_valid;
  assign page_close_policy = st_ff.page_close_policy;
  assign sysmem_freq_select = st_ff.sysmem_freq_select;
  assign graphics_device_select = st_ff.graphics_device_select;
  assign agp_device_enable = (st_ff.graphics_device_select == MPA_SEL_AGP);
  assign internal_graphics_claim = graphics_claim;
  assign precharge_bank = st_ff.precharge_bank;
  assign precharge_all = st_ff.precharge_all;
  assign refresh_go = st_ff.refresh_go;
  // aperture cycles are refused until software opens the aperture
  // one assignment for the whole struct keeps a single driver on the port
  assign aperture_grant = mpa_port_t'(aperture_req & {3{st_ff.aperture_enable}}); // [RULE9]

  // ****************************************
  // checks
  // ****************************************
  property p_bank_on_miss;
    @(posedge clock) disable iff (rst)
    (dram_evt.page_miss && !st_ff.page_close_policy && !dram_evt.refresh_req
      && !(dram_evt.row_switch && dram_evt.pages_open))
      |=> precharge_bank && !precharge_all;
  endproperty
  a_bank_on_miss: assert property (p_bank_on_miss) // [RULE1]
    else $error("page miss under open policy gave no bank precharge");

  property p_all_on_miss;
    @(posedge clock) disable iff (rst)
    (dram_evt.page_miss && st_ff.page_close_policy) |=> precharge_all && !precharge_bank;
  endproperty
  a_all_on_miss: assert property (p_all_on_miss) // [RULE2]
    else $error("page miss under closed policy gave no precharge all");

  property p_all_on_row;
    @(posedge clock) disable iff (rst)
    (dram_evt.row_switch && dram_evt.pages_open) |=> precharge_all;
  endproperty
  a_all_on_row: assert property (p_all_on_row) // [RULE3]
    else $error("row change with open pages gave no precharge all");

  property p_refresh_lead;
    @(posedge clock) disable iff (rst)
    dram_evt.refresh_req |=> precharge_all ##1 refresh_go;
  endproperty
  a_refresh_lead: assert property (p_refresh_lead) // [RULE4]
    else $error("refresh not led by precharge all");

  property p_freq_write;
    @(posedge clock) disable iff (rst)
    wr_memctl |=> sysmem_freq_select == $past(cfg_req.wdata[MPA_BIT_FREQ]);
  endproperty
  a_freq_write: assert property (p_freq_write) // [RULE5]
    else $error("frequency select did not take written value");

  property p_freq_strap;
    @(posedge clock)
    (!rst && $past(rst)) |-> sysmem_freq_select == $past(st_ff.strap_s2);
  endproperty
  a_freq_strap: assert property (p_freq_strap) // [RULE6]
    else $error("frequency select not loaded from strap");

  property p_lock_once;
    @(posedge clock) disable iff (rst)
    (wr_aperture && st_ff.lock_written) |=> $stable(st_ff.graphics_select_lock);
  endproperty
  a_lock_once: assert property (p_lock_once) // [RULE7]
    else $error("lock bit changed after first write");

  property p_sel_locked;
    @(posedge clock) disable iff (rst)
    st_ff.graphics_select_lock |=> $stable(graphics_device_select);
  endproperty
  a_sel_locked: assert property (p_sel_locked) // [RULE8]
    else $error("graphics select changed while locked");

  property p_ap_block;
    @(posedge clock) disable iff (rst)
    !st_ff.aperture_enable |-> aperture_grant == '0;
  endproperty
  a_ap_block: assert property (p_ap_block) // [RULE9]
    else $error("aperture granted while disabled");

  property p_dev2_ones;
    @(posedge clock) disable iff (rst)
    (cfg_req.rd && cfg_req.dev == MPA_DEV_GRAPHICS && !graphics_device_select)
      |=> cfg_rd_valid && cfg_rdata == MPA_ALL_ONES;
  endproperty
  a_dev2_ones: assert property (p_dev2_ones) // [RULE10]
    else $error("hidden device 2 read did not return ones");

  property p_dev1_ones;
    @(posedge clock) disable iff (rst)
    (cfg_req.rd && cfg_req.dev == MPA_DEV_AGP && graphics_device_select)
      |=> cfg_rdata == MPA_ALL_ONES && !$past(cfg_fwd_rd);
  endproperty
  a_dev1_ones: assert property (p_dev1_ones) // [RULE11]
    else $error("hidden device 1 read did not return ones");

  property p_gfx_smm;
    @(posedge clock) disable iff (rst)
    (cfg_req.wr && cfg_req.dev == MPA_DEV_GRAPHICS && smm_ram_control == MPA_SMM_OFF)
      |-> !cfg_fwd_wr;
  endproperty
  a_gfx_smm: assert property (p_gfx_smm) // [RULE12]
    else $error("internal graphics claimed cycle without smm setup");

  property p_reserved_zero;
    @(posedge clock) disable iff (rst)
    rd_aperture |=> cfg_rdata[7:3] == 5'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // [RULE15]
    else $error("reserved aperture bits read nonzero");

  property p_refresh_after_all;
    @(posedge clock) disable iff (rst)
    refresh_go |-> $past(precharge_all);
  endproperty
  a_refresh_after_all: assert property (p_refresh_after_all) // [RULE4]
    else $error("refresh started without precharge all before it");

  property p_policy_write;
    @(posedge clock) disable iff (rst)
    wr_memctl |=> page_close_policy == $past(cfg_req.wdata[MPA_BIT_POLICY]);
  endproperty
  a_policy_write: assert property (p_policy_write) // [RULE2]
    else $error("page close policy did not take written value");

  property p_grant_open;
    @(posedge clock) disable iff (rst)
    st_ff.aperture_enable |-> aperture_grant == aperture_req;
  endproperty
  a_grant_open: assert property (p_grant_open) // [RULE9]
    else $error("aperture refused while enabled");

  property p_dev1_shown;
    @(posedge clock) disable iff (rst)
    (cfg_req.rd && cfg_req.dev == MPA_DEV_AGP && !graphics_device_select) |-> cfg_fwd_rd;
  endproperty
  a_dev1_shown: assert property (p_dev1_shown) // [RULE10]
    else $error("device 1 read not passed on in agp mode");

  property p_agp_zero;
    @(posedge clock) disable iff (rst)
    (cfg_req.rd && cfg_req.dev == MPA_DEV_HOST && cfg_ext_agp_reg && graphics_device_select
      && cfg_req.off != MPA_OFF_MEMCTL && cfg_req.off != MPA_OFF_APERTURE)
      |=> cfg_rdata == MPA_ALL_ZEROS;
  endproperty
  a_agp_zero: assert property (p_agp_zero) // [RULE11]
    else $error("agp register read nonzero in internal graphics mode");

  property p_graphics_claim;
    @(posedge clock) disable iff (rst)
    (cfg_req.rd && cfg_req.dev == MPA_DEV_GRAPHICS && graphics_device_select
      && smm_ram_control != MPA_SMM_OFF) |-> cfg_fwd_rd;
  endproperty
  a_graphics_claim: assert property (p_graphics_claim) // [RULE12]
    else $error("internal graphics ignored a cycle it should claim");

endmodule

// ---- tb/memory_policy_aperture_control_tb_top.sv ----
// self-checking bench for the memory policy and aperture control block
`timescale 1ns/1ps
module memory_policy_aperture_control_tb_top
  import mpa_pkg::*;
;
  logic clock, rst, strap, agp_reg, fwd_rd, fwd_wr, rd_valid, policy, freq, sel;
  logic agp_en, claim, pre_bank, pre_all, ref_go, fwd_seen;
  logic [1:0] smm;
  logic [7:0] ext, rdata, rd_val;
  mpa_cfg_req_t cfg_req;
  mpa_dram_evt_t dram_evt;
  mpa_port_t ap_req, ap_grant;
  int fail_count, n_compared, cycles;

  mpa_ctrl i_mpa_ctrl (.clock(clock), .rst(rst), .sysmem_freq_strap_pin(strap),
    .cfg_req(cfg_req), .cfg_ext_rdata(ext), .cfg_ext_agp_reg(agp_reg),
    .smm_ram_control(smm), .dram_evt(dram_evt), .aperture_req(ap_req),
    .aperture_grant(ap_grant), .cfg_rdata(rdata), .cfg_rd_valid(rd_valid),
    .cfg_fwd_rd(fwd_rd), .cfg_fwd_wr(fwd_wr), .page_close_policy(policy),
    .sysmem_freq_select(freq), .graphics_device_select(sel),
    .agp_device_enable(agp_en), .internal_graphics_claim(claim),
    .precharge_bank(pre_bank), .precharge_all(pre_all), .refresh_go(ref_go));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one config access; the answer is taken one cycle after the request
  task automatic cfg(input logic rd, input logic [1:0] dev, input logic [7:0] off,
                     input logic [7:0] wd, input logic [7:0] ex, input logic ag);
    @(posedge clock);
    cfg_req <= '{rd: rd, wr: !rd, dev: dev, off: off, wdata: wd};
    ext <= ex;
    agp_reg <= ag;
    #1 fwd_seen = rd ? fwd_rd : fwd_wr;
    @(posedge clock);
    cfg_req <= '0;
    #1 rd_val = rdata;
    if (rd) chk("rd_valid", {7'h0, rd_valid}, 8'h01);
  endtask

  task automatic do_reset(input logic s);
    @(posedge clock);
    strap <= s;
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    #1 chk("freq after reset", {7'h0, freq}, {7'h0, s});
  endtask

  // pulse one event, then look at the two following cycles
  task automatic evt(input mpa_dram_evt_t e, input logic [2:0] exp1, input logic [2:0] exp2);
    @(posedge clock);
    dram_evt <= e;
    @(posedge clock);
    dram_evt <= '0;
    #1 chk("dram c1", {5'h0, pre_bank, pre_all, ref_go}, {5'h0, exp1});
    @(posedge clock);
    #1 chk("dram c2", {5'h0, pre_bank, pre_all, ref_go}, {5'h0, exp2});
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    do_reset(1'b1);
    cfg(1'b1, MPA_DEV_HOST, MPA_OFF_APERTURE, 8'h00, 8'hC3, 1'b0);
    chk("aperture_control", rd_val, MPA_APERTURE_RESET);
    chk("fwd 51h", {7'h0, fwd_seen}, 8'h00);
    chk("grant off", {5'h0, ap_grant}, 8'h00);
    cfg(1'b1, MPA_DEV_HOST, MPA_OFF_MEMCTL, 8'h00, 8'hA5, 1'b0);
    chk("memctl", rd_val, 8'hA4);
    $display("test reset done");
  endtask

  task automatic t_lock;
    cfg(1'b0, MPA_DEV_HOST, MPA_OFF_APERTURE, 8'hFF, 8'h00, 1'b0);
    cfg(1'b1, MPA_DEV_HOST, MPA_OFF_APERTURE, 8'h00, 8'h00, 1'b0);
    chk("aperture all set", rd_val, 8'h07);
    chk("grant on", {5'h0, ap_grant}, 8'h07);
    cfg(1'b0, MPA_DEV_HOST, MPA_OFF_APERTURE, 8'h00, 8'h00, 1'b0);
    cfg(1'b1, MPA_DEV_HOST, MPA_OFF_APERTURE, 8'h00, 8'h00, 1'b0);
    chk("aperture locked", rd_val, 8'h05);
    chk("select locked", {7'h0, sel}, 8'h01);
    chk("grant off again", {5'h0, ap_grant}, 8'h00);
    do_reset(1'b0);
    cfg(1'b0, MPA_DEV_HOST, MPA_OFF_APERTURE, 8'h02, 8'h00, 1'b0);
    cfg(1'b0, MPA_DEV_HOST, MPA_OFF_APERTURE, 8'h05, 8'h00, 1'b0);
    cfg(1'b1, MPA_DEV_HOST, MPA_OFF_APERTURE, 8'h00, 8'h00, 1'b0);
    chk("aperture second write", rd_val, 8'h01);
    cfg(1'b0, MPA_DEV_HOST, MPA_OFF_APERTURE, 8'h00, 8'h00, 1'b0);
    cfg(1'b1, MPA_DEV_HOST, MPA_OFF_APERTURE, 8'h00, 8'h00, 1'b0);
    chk("aperture select back", rd_val, 8'h00);
    $display("test lock done");
  endtask

  task automatic t_vis;
    cfg(1'b1, MPA_DEV_GRAPHICS, 8'h10, 8'h00, 8'h5A, 1'b0);
    chk("dev2 hidden", rd_val, MPA_ALL_ONES);
    cfg(1'b1, MPA_DEV_AGP, 8'h10, 8'h00, 8'h5A, 1'b0);
    chk("dev1 shown", rd_val, 8'h5A);
    chk("dev1 forwarded", {7'h0, fwd_seen}, 8'h01);
    chk("agp enable", {7'h0, agp_en}, 8'h01);
    cfg(1'b0, MPA_DEV_HOST, MPA_OFF_APERTURE, 8'h01, 8'h00, 1'b0);
    chk("select set", {6'h0, sel, agp_en}, 8'h02);
    cfg(1'b1, MPA_DEV_AGP, 8'h10, 8'h00, 8'h5A, 1'b0);
    chk("dev1 hidden", rd_val, MPA_ALL_ONES);
    cfg(1'b0, MPA_DEV_AGP, 8'h10, 8'h33, 8'h00, 1'b0);
    chk("dev1 write dropped", {7'h0, fwd_seen}, 8'h00);
    cfg(1'b1, MPA_DEV_HOST, 8'h60, 8'h00, 8'h5A, 1'b1);
    chk("agp reg zero", rd_val, MPA_ALL_ZEROS);
    cfg(1'b1, MPA_DEV_GRAPHICS, 8'h10, 8'h00, 8'h5A, 1'b0);
    chk("dev2 smm off", rd_val, MPA_ALL_ONES);
    chk("claim off", {7'h0, claim}, 8'h00);
    cfg(1'b0, MPA_DEV_GRAPHICS, 8'h10, 8'h44, 8'h00, 1'b0);
    chk("dev2 write dropped", {7'h0, fwd_seen}, 8'h00);
    @(posedge clock);
    smm <= 2'h3;
    cfg(1'b1, MPA_DEV_GRAPHICS, 8'h10, 8'h00, 8'h5A, 1'b0);
    chk("dev2 shown", rd_val, 8'h5A);
    chk("claim on", {7'h0, claim}, 8'h01);
    cfg(1'b0, MPA_DEV_GRAPHICS, 8'h10, 8'h44, 8'h00, 1'b0);
    chk("dev2 write passed", {7'h0, fwd_seen}, 8'h01);
    $display("test visibility done");
  endtask

  task automatic t_dram;
    evt(4'b1000, 3'b100, 3'b000);
    evt(4'b0110, 3'b010, 3'b000);
    evt(4'b0100, 3'b000, 3'b000);
    evt(4'b0001, 3'b010, 3'b001);
    cfg(1'b0, MPA_DEV_HOST, MPA_OFF_MEMCTL, 8'h0C, 8'h00, 1'b0);
    cfg(1'b1, MPA_DEV_HOST, MPA_OFF_MEMCTL, 8'h00, 8'h30, 1'b0);
    chk("memctl policy", rd_val, 8'h3C);
    chk("policy and freq", {6'h0, policy, freq}, 8'h03);
    evt(4'b1000, 3'b010, 3'b000);
    evt(4'b0001, 3'b010, 3'b001);
    $display("test dram done");
  endtask

  // ****************************************
  // run control
  // ****************************************
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    rst = 1'b1;
    strap = 1'b1;
    cfg_req = '0;
    ext = 8'h00;
    agp_reg = 1'b0;
    smm = 2'h0;
    dram_evt = '0;
    ap_req = 3'h7;
    t_reset();
    t_lock();
    t_vis();
    t_dram();
    give_verdict();
  end
endmodule
